// ---- core/tme_encoder.sv ----
// tme_encoder.sv: trunking message encoder with apb registers
// assumes synchronous inputs, 20 MHz sys_clk_i, apb master outside
//
// Contract
// - frame is sync,area,goto,home,id,free,check
// - bit rate programmable, resets to 297.6 bps
// - two parameter sets, selector picks one
// - each set fills area, repeaters, identity
// - start command begins emitting bit stream
// - single mode sends message once then idles
// - burst mode sends programmed count of frames
// - continuous mode repeats until stop arrives
// - stop finishes current frame, no truncation
// - invert maps one to negative excursion
// - step mode produces no output
//
// Implementation choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "tme_map.svh"
module tme_encoder
    import tme_pkg::*;
#(
    parameter logic [8:0]  SYNC_WORD   = `TME_SYNC_DEF,
    parameter logic [31:0] BIT_CYC_DEF = 32'(`TME_BIT_CYC_DEF),
    parameter int          FIFO_DEPTH  = 16
) (
    input  wire logic        sys_clk_i,
    input  wire logic        nrst_i,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic             mod_data_o,
    output logic             mod_pos_o,
    output logic             mod_neg_o,
    output logic             busy_o
);
    // ------------------------------------------------------------
    // frame helpers
    // ------------------------------------------------------------
    // replaceable check: 7-bit crc over the 24 payload bits
    function automatic logic [6:0] check_bits(input logic [23:0] d);
        logic [6:0] c;
        c = '0;
        for (int i = 23; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((c[6] ^ d[i]) ? 7'h09 : 7'h00);
        end
        check_bits = c;
    endfunction

    function automatic tme_msg_t unpack_msg(input logic [31:0] w);
        unpack_msg.area     = w[`TME_MSG_AREA_BIT];
        unpack_msg.goto_rpt = w[`TME_MSG_GOTO_LSB +: 5];
        unpack_msg.home_rpt = w[`TME_MSG_HOME_LSB +: 5];
        unpack_msg.radio_id = w[`TME_MSG_ID_LSB +: 8];
        unpack_msg.free_rpt = w[`TME_MSG_FREE_LSB +: 5];
    endfunction

    function automatic logic [31:0] pack_msg(input tme_msg_t m);
        pack_msg = {8'h00, m.free_rpt, m.radio_id, m.home_rpt, m.goto_rpt, m.area};
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    tme_mode_t   mode_q,    mode_d;
    logic        sel_q,     sel_d;
    logic        inv_q,     inv_d;
    logic [7:0]  count_q,   count_d;
    logic [31:0] rate_q,    rate_d;
    tme_msg_t    msg_a_q,   msg_a_d;
    tme_msg_t    msg_b_q,   msg_b_d;
    logic [31:0] prdata_d;
    logic        pready_d;
    logic        pslverr_d;
    logic        start_p;
    logic        stop_p;
    logic        acc;
    logic        commit;
    logic        hit;

    assign acc    = psel & penable & ~pready;
    assign commit = psel & penable & pready & pwrite;

    always_comb begin
        mode_d    = mode_q;
        sel_d     = sel_q;
        inv_d     = inv_q;
        count_d   = count_q;
        rate_d    = rate_q;
        msg_a_d   = msg_a_q;
        msg_b_d   = msg_b_q;
        prdata_d  = '0;
        pready_d  = acc;
        pslverr_d = 1'b0;
        start_p   = 1'b0;
        stop_p    = 1'b0;
        hit       = 1'b1;
        case (paddr)
            `TME_OFF_CTRL: prdata_d = {16'h0000, count_q, 4'h0, inv_q, sel_q, mode_q};
            `TME_OFF_CMD:  prdata_d = '0;
            `TME_OFF_STAT: prdata_d = {31'h0, busy_o};
            `TME_OFF_RATE: prdata_d = rate_q;
            `TME_OFF_MSG_A: prdata_d = pack_msg(msg_a_q);
            `TME_OFF_MSG_B: prdata_d = pack_msg(msg_b_q);
            default: hit = 1'b0;
        endcase
        if (acc) begin
            pslverr_d = ~hit;
            if (!pwrite || !hit) begin
                prdata_d = hit ? prdata_d : 32'h0000_0000;
            end
            if (pwrite) begin
                prdata_d = '0;
            end
        end else begin
            prdata_d = '0;
        end
        // writes land at the edge where the master samples pready high
        if (commit) begin
            case (paddr)
                `TME_OFF_CTRL: begin
                    mode_d  = tme_mode_t'(pwdata[`TME_CTRL_MODE_LSB +: 2]);
                    sel_d   = pwdata[`TME_CTRL_SEL_BIT];
                    inv_d   = pwdata[`TME_CTRL_POL_BIT];
                    count_d = pwdata[`TME_CTRL_CNT_LSB +: 8];
                end
                `TME_OFF_CMD: begin
                    start_p = pwdata[`TME_CMD_START_BIT];
                    stop_p  = pwdata[`TME_CMD_STOP_BIT];
                end
                `TME_OFF_RATE:  rate_d  = (pwdata == '0) ? 32'h0000_0001 : pwdata;
                `TME_OFF_MSG_A: msg_a_d = unpack_msg(pwdata);
                `TME_OFF_MSG_B: msg_b_d = unpack_msg(pwdata);
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mode_q  <= TME_MODE_SINGLE;
            sel_q   <= 1'b0;
            inv_q   <= 1'b0;
            count_q <= 8'h01;
            rate_q  <= BIT_CYC_DEF;
            msg_a_q <= '0;
            msg_b_q <= '0;
            prdata  <= '0;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            mode_q  <= mode_d;
            sel_q   <= sel_d;
            inv_q   <= inv_d;
            count_q <= count_d;
            rate_q  <= rate_d;
            msg_a_q <= msg_a_d;
            msg_b_q <= msg_b_d;
            prdata  <= prdata_d;
            pready  <= pready_d;
            pslverr <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // frame builder, feeds the bit fifo
    // ------------------------------------------------------------
    tme_fifo_if #(.WIDTH(1)) bits_if ();

    tme_fifo #(
        .WIDTH (1),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .sys_clk_i (sys_clk_i),
        .nrst_i    (nrst_i),
        .port      (bits_if)
    );

    tme_state_t  st_q,    st_d;
    logic [39:0] frame_q, frame_d;
    logic [5:0]  bit_q,   bit_d;
    logic [7:0]  left_q,  left_d;
    logic        stop_q,  stop_d;
    tme_mode_t   run_q,   run_d;
    tme_msg_t    cur;
    logic [23:0] payload;

    always_comb begin
        cur     = sel_q ? msg_b_q : msg_a_q;
        payload = {cur.area, cur.goto_rpt, cur.home_rpt, cur.radio_id, cur.free_rpt};
        st_d    = st_q;
        frame_d = frame_q;
        bit_d   = bit_q;
        left_d  = left_q;
        stop_d  = stop_q | stop_p;
        run_d   = run_q;
        case (st_q)
            TME_ST_IDLE: begin
                stop_d = 1'b0;
                if (start_p && mode_q != TME_MODE_STEP) begin
                    run_d  = mode_q;
                    left_d = (count_q == '0) ? 8'h01 : count_q;
                    st_d   = TME_ST_LOAD;
                end
            end
            TME_ST_LOAD: begin
                frame_d = {SYNC_WORD, payload, check_bits(payload)};
                bit_d   = 6'(`TME_FRAME_BITS - 1);
                st_d    = TME_ST_SEND;
            end
            TME_ST_SEND: begin
                if (bits_if.wr_ready) begin
                    bit_d = bit_q - 1'b1;
                    if (bit_q == '0) begin
                        // frame done: decide at the boundary only
                        if (run_q == TME_MODE_SINGLE) begin
                            st_d = TME_ST_IDLE;
                        end else if (stop_d) begin
                            st_d = TME_ST_IDLE;
                        end else if (run_q == TME_MODE_BURST) begin
                            left_d = left_q - 1'b1;
                            st_d   = (left_q == 8'h01) ? TME_ST_IDLE : TME_ST_LOAD;
                        end else begin
                            st_d = TME_ST_LOAD;
                        end
                    end
                end
            end
            default: st_d = TME_ST_IDLE;
        endcase
    end

    assign bits_if.wr_valid = (st_q == TME_ST_SEND);
    assign bits_if.wr_data  = frame_q[bit_q];

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            st_q    <= TME_ST_IDLE;
            frame_q <= '0;
            bit_q   <= '0;
            left_q  <= '0;
            stop_q  <= 1'b0;
            run_q   <= TME_MODE_SINGLE;
        end else begin
            st_q    <= st_d;
            frame_q <= frame_d;
            bit_q   <= bit_d;
            left_q  <= left_d;
            stop_q  <= stop_d;
            run_q   <= run_d;
        end
    end

    // ------------------------------------------------------------
    // bit timer, drains the fifo at the signalling rate
    // ------------------------------------------------------------
    logic [31:0] tick_q,  tick_d;
    logic        out_q,   out_d;
    logic        act_q,   act_d;
    logic        pos_d,   neg_d;
    logic        busy_d;
    logic        take;

    assign take             = bits_if.rd_valid && (tick_q == '0);
    assign bits_if.rd_ready = (tick_q == '0);

    always_comb begin
        tick_d = (tick_q == '0) ? (take ? rate_q - 1'b1 : '0) : tick_q - 1'b1;
        out_d  = take ? bits_if.rd_data : out_q;
        act_d  = take ? 1'b1 : ((tick_q == '0) ? 1'b0 : act_q);
        pos_d  = act_d & (out_d ^ inv_q);
        neg_d  = act_d & ~(out_d ^ inv_q);
        busy_d = (st_d != TME_ST_IDLE) | act_d | bits_if.rd_valid;
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tick_q     <= '0;
            out_q      <= 1'b0;
            act_q      <= 1'b0;
            mod_data_o <= 1'b0;
            mod_pos_o  <= 1'b0;
            mod_neg_o  <= 1'b0;
            busy_o     <= 1'b0;
        end else begin
            tick_q     <= tick_d;
            out_q      <= out_d;
            act_q      <= act_d;
            mod_data_o <= out_d;
            mod_pos_o  <= pos_d;
            mod_neg_o  <= neg_d;
            busy_o     <= busy_d;
        end
    end
endmodule
`default_nettype wire

// ---- core/tme_fifo.sv ----
// tme_fifo.sv: flip-flop fifo with valid/ready on both sides
// assumes a single clock and an active-low asynchronous reset
`timescale 1ns/10ps
`default_nettype none
module tme_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 16
) (
    input  wire logic sys_clk_i,
    input  wire logic nrst_i,
    tme_fifo_if.fifo  port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [AW-1:0]    wptr_q;
    logic [AW-1:0]    wptr_d;
    logic [AW-1:0]    rptr_q;
    logic [AW-1:0]    rptr_d;
    logic [AW:0]      cnt_q;
    logic [AW:0]      cnt_d;
    logic             push;
    logic             pop;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
    endfunction

    assign port.wr_ready = (cnt_q != (AW+1)'(DEPTH));
    assign port.rd_valid = (cnt_q != '0);
    assign port.rd_data  = mem_q[rptr_q];
    assign push          = port.wr_valid & port.wr_ready;
    assign pop           = port.rd_valid & port.rd_ready;

    always_comb begin
        mem_d  = mem_q;
        wptr_d = wptr_q;
        rptr_d = rptr_q;
        cnt_d  = cnt_q;
        if (push) begin
            mem_d[wptr_q] = port.wr_data;
            wptr_d        = bump(wptr_q);
        end
        if (pop) begin
            rptr_d = bump(rptr_q);
        end
        if (push && !pop) begin
            cnt_d = cnt_q + 1'b1;
        end else if (pop && !push) begin
            cnt_d = cnt_q - 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q  <= '0;
        end else begin
            mem_q  <= mem_d;
            wptr_q <= wptr_d;
            rptr_q <= rptr_d;
            cnt_q  <= cnt_d;
        end
    end
endmodule
`default_nettype wire

// ---- core/tme_fifo_if.sv ----
// tme_fifo_if.sv: valid/ready carrier between encoder and its bit fifo
// assumes one clock domain shared by both sides
`timescale 1ns/10ps
`default_nettype none
interface tme_fifo_if #(
    parameter int WIDTH = 1
);
    logic             wr_valid;
    logic             wr_ready;
    logic [WIDTH-1:0] wr_data;
    logic             rd_valid;
    logic             rd_ready;
    logic [WIDTH-1:0] rd_data;

    modport fifo (
        input  wr_valid,
        input  wr_data,
        output wr_ready,
        output rd_valid,
        output rd_data,
        input  rd_ready
    );
    modport user (
        output wr_valid,
        output wr_data,
        input  wr_ready,
        input  rd_valid,
        input  rd_data,
        output rd_ready
    );
endinterface
`default_nettype wire

// ---- core/tme_map.svh ----
// tme_map.svh: offsets, field positions, reset values and timing counts
// assumes a 20 MHz system clock and a 32-bit apb register bus
`ifndef TME_MAP_SVH
`define TME_MAP_SVH

`define TME_CLK_HZ          20000000
`define TME_RATE_MHZ_DEF    297600
`define TME_BIT_CYC_DEF     ((`TME_CLK_HZ * 64'd1000) / `TME_RATE_MHZ_DEF)

`define TME_OFF_CTRL        12'h000
`define TME_OFF_CMD         12'h004
`define TME_OFF_STAT        12'h008
`define TME_OFF_RATE        12'h00C
`define TME_OFF_MSG_A       12'h010
`define TME_OFF_MSG_B       12'h014

`define TME_CTRL_MODE_LSB   0
`define TME_CTRL_SEL_BIT    2
`define TME_CTRL_POL_BIT    3
`define TME_CTRL_CNT_LSB    8
`define TME_CMD_START_BIT   0
`define TME_CMD_STOP_BIT    1

`define TME_MSG_AREA_BIT    0
`define TME_MSG_GOTO_LSB    1
`define TME_MSG_HOME_LSB    6
`define TME_MSG_ID_LSB      11
`define TME_MSG_FREE_LSB    19

`define TME_FRAME_BITS      40
`define TME_SYNC_W          9
`define TME_CHK_W           7
`define TME_SYNC_DEF        9'h0AC

`endif

// ---- core/tme_pkg.sv ----
// tme_pkg.sv: types shared by the trunking message encoder
// assumes nothing beyond a systemverilog compiler
package tme_pkg;

    typedef enum logic [1:0] {
        TME_MODE_SINGLE = 2'h0,
        TME_MODE_BURST  = 2'h1,
        TME_MODE_CONT   = 2'h2,
        TME_MODE_STEP   = 2'h3
    } tme_mode_t;

    typedef enum logic [1:0] {
        TME_ST_IDLE = 2'h0,
        TME_ST_LOAD = 2'h1,
        TME_ST_SEND = 2'h3
    } tme_state_t;

    typedef struct packed {
        logic       area;
        logic [4:0] goto_rpt;
        logic [4:0] home_rpt;
        logic [7:0] radio_id;
        logic [4:0] free_rpt;
    } tme_msg_t;

endpackage

// ---- test/tme_encoder_sva.sv ----
// tme_encoder_sva.sv: port-level assertions for the trunking message encoder
// assumes invert and rate are only rewritten while no frame is on the line
`timescale 1ns/10ps
`default_nettype none
module tme_encoder_sva #(
    parameter logic [31:0] BIT_CYC_DEF = 32'h4
) (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        mod_data_o,
    input wire logic        mod_pos_o,
    input wire logic        mod_neg_o,
    input wire logic        busy_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!nrst_i);
    logic        inv_q;
    logic [1:0]  mode_q;
    logic [1:0]  pn_q;
    logic [31:0] rate_q;
    logic [31:0] run_q;
    wire         wr  = psel && penable && pready && pwrite;
    wire         go  = wr && paddr == 12'h004 && pwdata[0];
    wire         act = mod_pos_o || mod_neg_o;
    // shadow of control fields and length of the current excursion
    always_ff @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            inv_q  <= 1'b0;
            mode_q <= 2'h0;
            rate_q <= BIT_CYC_DEF;
            pn_q   <= 2'h0;
            run_q  <= 32'h0;
        end else begin
            if (wr && paddr == 12'h000) begin
                inv_q  <= pwdata[3];
                mode_q <= pwdata[1:0];
            end
            if (wr && paddr == 12'h00C) begin
                rate_q <= (pwdata == 32'h0) ? 32'h1 : pwdata;
            end
            pn_q  <= {mod_pos_o, mod_neg_o};
            run_q <= ({mod_pos_o, mod_neg_o} != pn_q) ? 32'h1 : run_q + 32'h1;
        end
    end
    chk_ready_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready not one cycle after access start");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_ready_cause: assert property (pready |-> $past(psel) && $past(penable) && !$past(pready))
        else $error("pready without an access");
    chk_err_map: assert property (pready |-> pslverr == (paddr > 12'h014 || paddr[1:0] != 2'h0))
        else $error("pslverr does not match address map");
    chk_err_zero: assert property (pready && pslverr |-> prdata == 32'h0)
        else $error("refused read returned data");
    chk_exc_excl: assert property (!(mod_pos_o && mod_neg_o))
        else $error("both excursions at once");
    chk_pol_map: assert property (act |-> mod_pos_o == (mod_data_o ^ inv_q))
        else $error("excursion does not follow bit and polarity");
    chk_bit_hold: assert property (act && pn_q != 2'h0 && {mod_pos_o, mod_neg_o} != pn_q |-> run_q >= rate_q)
        else $error("bit shorter than rate");
    chk_step_quiet: assert property (go && mode_q == 2'h3 && !busy_o |=> !busy_o [*8])
        else $error("step mode started a sequence");
    chk_start_busy: assert property (go && mode_q != 2'h3 && !busy_o |-> ##[1:4] busy_o)
        else $error("start did not begin a sequence");
endmodule
bind tme_encoder tme_encoder_sva #(.BIT_CYC_DEF(BIT_CYC_DEF)) chk_u (.sys_clk_i, .nrst_i, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mod_data_o, .mod_pos_o, .mod_neg_o, .busy_o);
`default_nettype wire

// ---- test/tme_radio_model.sv ----
// tme_radio_model.sv: receiving radio, slices excursions into 40-bit frames
// assumes bench tells it the polarity and cycles per bit in use
`timescale 1ns/10ps
`default_nettype none
module tme_radio_model (
    input wire logic        sys_clk_i,
    input wire logic        nrst_i,
    input wire logic        mod_pos_i,
    input wire logic        mod_neg_i,
    input wire logic        inv_i,
    input wire logic [31:0] rate_i
);
    logic [39:0] frames[$];
    logic [39:0] sr;
    logic        rx;
    int          nb;
    int          ph;
    // sample each bit in mid-period while an excursion is present
    always @(posedge sys_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rx = 1'b0;
            nb = 0;
        end else if (!(mod_pos_i || mod_neg_i)) begin
            rx = 1'b0;
        end else begin
            if (!rx) begin
                ph = 0;
            end
            rx = 1'b1;
            if (ph == rate_i / 2) begin
                sr = {sr[38:0], inv_i ? mod_neg_i : mod_pos_i};
                nb++;
                if (nb % 40 == 0) begin
                    frames.push_back(sr);
                end
            end
            ph = (ph + 1) % rate_i;
        end
    end
endmodule
`default_nettype wire

// ---- test/trunking_message_encoder_tb.sv ----
// trunking_message_encoder_tb.sv: random and corner runs of every send mode
// assumes the encoder, its fifo and the radio model are compiled first
`timescale 1ns/10ps
`default_nettype none
module trunking_message_encoder_tb;
    import tme_pkg::*;
    localparam logic [8:0]  SYNCW = 9'h0AC;
    localparam logic [31:0] BITC  = 32'h4;
    logic        clk, nrst, psel, penable, pwrite, pready, pslverr;
    logic        mdata, mpos, mneg, busy, inv, err, s0;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, lf, rate;
    tme_msg_t    ma, mb;
    int          n_fail, total_checks;

    tme_encoder #(.SYNC_WORD(SYNCW), .BIT_CYC_DEF(BITC), .FIFO_DEPTH(16)) dut_u (
        .sys_clk_i(clk), .nrst_i(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mod_data_o(mdata), .mod_pos_o(mpos), .mod_neg_o(mneg), .busy_o(busy));
    tme_radio_model partner_u (.sys_clk_i(clk), .nrst_i(nrst), .mod_pos_i(mpos),
        .mod_neg_i(mneg), .inv_i(inv), .rate_i(rate));

    function automatic logic [31:0] nxt(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [39:0] frm(input tme_msg_t m);
        logic [6:0] c;
        c = 7'h00;
        for (int i = 23; i >= 0; i--) begin
            c = {c[5:0], 1'b0} ^ ((m[i] ^ c[6]) ? 7'h09 : 7'h00);
        end
        return {SYNCW, m, c};
    endfunction
    function automatic logic [31:0] wrd(input tme_msg_t m);
        return {8'h00, m.free_rpt, m.radio_id, m.home_rpt, m.goto_rpt, m.area};
    endfunction
    task automatic give_verdict(input bit to);
        if (to) n_fail++;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        total_checks++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] t=%0t seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) give_verdict(1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic idle();
        int k;
        k = 0;
        repeat (4) @(posedge clk);
        while (busy !== 1'b0 && k < 9000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 9000) give_verdict(1);
        repeat (8) @(posedge clk);
    endtask
    task automatic wf(input int n);
        int k;
        k = 0;
        while (partner_u.frames.size() < n && k < 9000) begin
            @(posedge clk);
            k++;
        end
        if (k >= 9000) give_verdict(1);
    endtask
    task automatic start(input logic [1:0] md, input logic s, input logic p, input logic [7:0] c);
        lf = nxt(lf);
        ma = lf[23:0];
        lf = nxt(lf);
        mb = lf[23:0];
        ma.radio_id = 8'hFF;
        apb(1'b1, 12'h010, wrd(ma));
        apb(1'b1, 12'h014, wrd(mb));
        apb(1'b1, 12'h000, {16'h0000, c, 4'h0, p, s, md});
        inv = p;
        partner_u.frames.delete();
        apb(1'b1, 12'h004, 32'h1);
    endtask
    task automatic cf(input int n, input tme_msg_t m);
        chk(partner_u.frames.size(), n);
        foreach (partner_u.frames[i]) chk(partner_u.frames[i], frm(m));
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    // ---------------------------------------------
    // scenarios
    // ---------------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, inv} = 5'h00;
        paddr = 12'h000;
        pwdata = 32'h0;
        lf = 32'h305F9C2F;
        rate = BITC;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (2) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        chk(rd, 32'h100);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, BITC);
        apb(1'b0, 12'h014, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h018, 32'h0);
        chk({err, rd}, {1'b1, 32'h0});
        apb(1'b1, 12'h3FC, 32'hFFFFFFFF);
        chk(err, 1'b1);
        $display("registers done");
        for (int i = 0; i < 3; i++) begin
            s0 = lf[0];
            start(2'h0, s0, lf[1], 8'h05);
            apb(1'b1, 12'h004, 32'h1);
            idle();
            cf(1, s0 ? mb : ma);
        end
        $display("single done");
        start(2'h1, 1'b1, 1'b1, 8'h03);
        apb(1'b1, 12'h004, 32'h1);
        apb(1'b0, 12'h008, 32'h0);
        chk({busy, rd}, {1'b1, 32'h1});
        idle();
        cf(3, mb);
        start(2'h1, 1'b0, 1'b0, 8'h05);
        wf(1);
        apb(1'b1, 12'h004, 32'h2);
        idle();
        cf(2, ma);
        $display("burst done");
        apb(1'b1, 12'h00C, 32'h6);
        rate = 32'h6;
        start(2'h0, 1'b0, 1'b0, 8'h01);
        idle();
        cf(1, ma);
        apb(1'b1, 12'h00C, 32'h0);
        apb(1'b0, 12'h00C, 32'h0);
        chk(rd, 32'h1);
        apb(1'b1, 12'h00C, BITC);
        rate = BITC;
        $display("rate done");
        start(2'h2, 1'b0, 1'b0, 8'h01);
        wf(2);
        apb(1'b1, 12'h000, 32'h106);
        wf(4);
        apb(1'b1, 12'h004, 32'h2);
        idle();
        foreach (partner_u.frames[i]) begin
            chk(partner_u.frames[i] === frm(ma) || partner_u.frames[i] === frm(mb), 1'b1);
        end
        chk(partner_u.frames[partner_u.frames.size() - 1], frm(mb));
        chk(partner_u.nb % 40, 0);
        $display("continuous done");
        start(2'h3, 1'b0, 1'b0, 8'h01);
        idle();
        chk(partner_u.frames.size(), 0);
        $display("step done");
        give_verdict(0);
    end
endmodule
`default_nettype wire
